// ===== core/fecdc_pkg.sv
// Shared constants and types of the Fast Ethernet line codec.
package fecdc_pkg;
  // Clock cycles per line bit and line bits per code group.
  localparam int OVS = 4;
  localparam int GRP_BITS = 5;
  localparam int NIB_CLKS = OVS * GRP_BITS;
  localparam logic [1:0] OVS_LAST = 2'(OVS - 1);
  localparam logic [2:0] GRP_LAST = 3'(GRP_BITS - 1);
  // Receive sampling phase inside one line bit.
  localparam logic [1:0] RX_SAMPLE_PH = 2'h2;
  // Line bits without a transition before clock lock is dropped.
  localparam int LOCK_BITS = 64;
  localparam logic [6:0] LOCK_LAST = 7'(LOCK_BITS - 1);
  // Line bits the descrambler loads from the idle stream before it runs.
  localparam int DESC_LOAD = 11;
  localparam logic [3:0] DESC_LAST = 4'(DESC_LOAD - 1);
  // Scrambler register seed and feedback taps.
  localparam logic [10:0] SCR_SEED = 11'h7ff;
  localparam int SCR_TAP_A = 10;
  localparam int SCR_TAP_B = 8;
  // Control code groups.
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0d;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_H = 5'h04;
  // Sample data code groups.
  localparam logic [4:0] CG_D0 = 5'h1e;
  localparam logic [4:0] CG_DF = 5'h1d;
  // Preamble nibble that replaces the start pair.
  localparam logic [3:0] NIB_PRE = 4'h5;

  typedef enum logic [2:0] {
    SYM_DATA, SYM_IDLE, SYM_J, SYM_K, SYM_T, SYM_R, SYM_H, SYM_BAD
  } fecdc_sym_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_J, TX_DATA, TX_T, TX_R
  } fecdc_txst_t;

  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } fecdc_mii_t;

  typedef struct packed {
    logic p;
    logic n;
  } fecdc_mlt_t;
endpackage

// ===== core/fecdc_lut.sv
// Code group lookup tables for both directions.
`timescale 1ns/1ps
module fecdc_lut (
  // Transmit nibble to code group
  input wire logic [3:0] enc_nib_i,
  output logic [4:0] enc_grp_o,
  // Receive code group to nibble
  input wire logic [4:0] dec_grp_i,
  output logic [3:0] dec_nib_o,
  output fecdc_pkg::fecdc_sym_t dec_sym_o
);
  always_comb
  begin
    unique case (enc_nib_i)
      4'h0: enc_grp_o = 5'h1e;
      4'h1: enc_grp_o = 5'h09;
      4'h2: enc_grp_o = 5'h14;
      4'h3: enc_grp_o = 5'h15;
      4'h4: enc_grp_o = 5'h0a;
      4'h5: enc_grp_o = 5'h0b;
      4'h6: enc_grp_o = 5'h0e;
      4'h7: enc_grp_o = 5'h0f;
      4'h8: enc_grp_o = 5'h12;
      4'h9: enc_grp_o = 5'h13;
      4'ha: enc_grp_o = 5'h16;
      4'hb: enc_grp_o = 5'h17;
      4'hc: enc_grp_o = 5'h1a;
      4'hd: enc_grp_o = 5'h1b;
      4'he: enc_grp_o = 5'h1c;
      4'hf: enc_grp_o = 5'h1d;
    endcase
  end

  always_comb
  begin
    dec_nib_o = 4'h0;
    dec_sym_o = fecdc_pkg::SYM_DATA;
    unique case (dec_grp_i)
      5'h1e: dec_nib_o = 4'h0;
      5'h09: dec_nib_o = 4'h1;
      5'h14: dec_nib_o = 4'h2;
      5'h15: dec_nib_o = 4'h3;
      5'h0a: dec_nib_o = 4'h4;
      5'h0b: dec_nib_o = 4'h5;
      5'h0e: dec_nib_o = 4'h6;
      5'h0f: dec_nib_o = 4'h7;
      5'h12: dec_nib_o = 4'h8;
      5'h13: dec_nib_o = 4'h9;
      5'h16: dec_nib_o = 4'ha;
      5'h17: dec_nib_o = 4'hb;
      5'h1a: dec_nib_o = 4'hc;
      5'h1b: dec_nib_o = 4'hd;
      5'h1c: dec_nib_o = 4'he;
      5'h1d: dec_nib_o = 4'hf;
      fecdc_pkg::CG_IDLE: dec_sym_o = fecdc_pkg::SYM_IDLE;
      fecdc_pkg::CG_J: dec_sym_o = fecdc_pkg::SYM_J;
      fecdc_pkg::CG_K: dec_sym_o = fecdc_pkg::SYM_K;
      fecdc_pkg::CG_T: dec_sym_o = fecdc_pkg::SYM_T;
      fecdc_pkg::CG_R: dec_sym_o = fecdc_pkg::SYM_R;
      fecdc_pkg::CG_H: dec_sym_o = fecdc_pkg::SYM_H;
      default: dec_sym_o = fecdc_pkg::SYM_BAD;
    endcase
  end
endmodule // fecdc_lut

// ===== core/fecdc_lfsr.sv
// Eleven-bit scrambler key generator, used for both scrambling directions.
`timescale 1ns/1ps
module fecdc_lfsr (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Control
  input wire logic step_i,
  input wire logic load_i,
  input wire logic feed_i,
  // Key bit
  output logic key_o
);
  logic [10:0] state_q;

  assign key_o = state_q[fecdc_pkg::SCR_TAP_A] ^ state_q[fecdc_pkg::SCR_TAP_B];

  // Loading from the line lets the receive copy fall into step with the
  // far transmitter without any shared seed.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      state_q <= fecdc_pkg::SCR_SEED;
    else if (step_i)
      state_q <= {state_q[9:0], load_i ? feed_i : key_o};
  end
endmodule // fecdc_lfsr

// ===== core/fecdc_top.sv
// Fast Ethernet 100 Mb/s transmit and receive line coding path.
`timescale 1ns/1ps
module fecdc_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Transmit MII side
  input wire fecdc_pkg::fecdc_mii_t tx_mii_i,
  input wire logic tx_sym4_i,
  input wire logic bypass_i,
  output logic tx_nib_stb_o,
  // Transmit line side
  output fecdc_pkg::fecdc_mlt_t tx_mlt_o,
  // Receive line side
  input wire fecdc_pkg::fecdc_mlt_t rx_mlt_i,
  // Receive MII side
  output fecdc_pkg::fecdc_mii_t rx_mii_o,
  output logic rx_nib_stb_o,
  output logic rx_lock_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  logic [1:0] tx_ph_q;
  logic [2:0] tx_bi_q;
  logic bit_en_q;
  logic nib_en_q;
  fecdc_pkg::fecdc_txst_t tx_st_q, tx_st_d;
  logic [4:0] tx_grp_q, tx_grp_d, enc_grp;
  logic [4:0] tx_sh_q;
  logic tx_key, tx_bit, tx_nrz;
  logic tx_nrzi_q, tx_nrzi_d;
  logic [1:0] mlt_st_q, mlt_st_d;
  fecdc_pkg::fecdc_mlt_t rx_s1_q, rx_s2_q, rx_s3_q, rx_smp_q;
  logic [1:0] rx_ph_q;
  logic [6:0] lock_cnt_q;
  logic rx_trans, rx_bit_en;
  logic rx_nrzi_q, rx_nrzi_d, rx_nrz, rx_key, rx_plain;
  logic [3:0] desc_cnt_q;
  logic desc_lock_q;
  logic [9:0] rx_win_q;
  logic rx_chk_q;
  logic aligned_q, saw_t_q, ending_q;
  logic [2:0] grp_cnt_q;
  logic jk_hit, grp_rdy;
  logic [3:0] dec_nib;
  fecdc_pkg::fecdc_sym_t dec_sym;
  fecdc_pkg::fecdc_mii_t rx_stage_q;

  // Bit and nibble enables from one divider chain.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      tx_ph_q <= 2'h0;
      tx_bi_q <= 3'h0;
      bit_en_q <= 1'b0;
      nib_en_q <= 1'b0;
    end
    else
    begin
      tx_ph_q <= tx_ph_q + 2'h1;
      bit_en_q <= tx_ph_q == fecdc_pkg::OVS_LAST;
      nib_en_q <= tx_ph_q == fecdc_pkg::OVS_LAST &&
                  tx_bi_q == fecdc_pkg::GRP_LAST;
      if (tx_ph_q == fecdc_pkg::OVS_LAST)
        tx_bi_q <= tx_bi_q == fecdc_pkg::GRP_LAST ? 3'h0 : tx_bi_q + 3'h1;
    end
  end

  assign tx_nib_stb_o = nib_en_q;

  fecdc_lut u_lut (
    .enc_nib_i(tx_mii_i.d),
    .enc_grp_o(enc_grp),
    .dec_grp_i(rx_win_q[4:0]),
    .dec_nib_o(dec_nib),
    .dec_sym_o(dec_sym)
  );

  always_comb
  begin
    tx_st_d = tx_st_q;
    tx_grp_d = fecdc_pkg::CG_IDLE;
    unique case (tx_st_q)
      fecdc_pkg::TX_IDLE:
        if (tx_mii_i.en)
        begin
          tx_grp_d = fecdc_pkg::CG_J;
          tx_st_d = fecdc_pkg::TX_J;
        end
      fecdc_pkg::TX_J:
      begin
        tx_grp_d = fecdc_pkg::CG_K;
        tx_st_d = fecdc_pkg::TX_DATA;
      end
      fecdc_pkg::TX_DATA:
        if (tx_mii_i.en && bypass_i)
          tx_grp_d = {tx_sym4_i, tx_mii_i.d};
        else if (tx_mii_i.en && tx_mii_i.er)
          tx_grp_d = fecdc_pkg::CG_H;
        else if (tx_mii_i.en)
          tx_grp_d = enc_grp;
        else
        begin
          tx_grp_d = fecdc_pkg::CG_T;
          tx_st_d = fecdc_pkg::TX_T;
        end
      fecdc_pkg::TX_T:
      begin
        tx_grp_d = fecdc_pkg::CG_R;
        tx_st_d = fecdc_pkg::TX_R;
      end
      fecdc_pkg::TX_R:
        tx_st_d = fecdc_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      tx_st_q <= fecdc_pkg::TX_IDLE;
      tx_grp_q <= fecdc_pkg::CG_IDLE;
    end
    else if (nib_en_q)
    begin
      tx_st_q <= tx_st_d;
      tx_grp_q <= tx_grp_d;
    end
  end

  // Group bit 4 leaves first; the shift register holds the rest.
  assign tx_bit = nib_en_q ? tx_grp_d[4] : tx_sh_q[3];
  assign tx_nrz = tx_bit ^ tx_key;
  assign tx_nrzi_d = tx_nrzi_q ^ tx_nrz;
  // each NRZI transition steps the three-level cycle
  assign mlt_st_d = mlt_st_q + {1'b0, tx_nrzi_d ^ tx_nrzi_q};

  fecdc_lfsr u_scr (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .step_i(bit_en_q),
    .load_i(1'b0),
    .feed_i(1'b0),
    .key_o(tx_key)
  );

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      tx_sh_q <= fecdc_pkg::CG_IDLE;
      tx_nrzi_q <= 1'b0;
      mlt_st_q <= 2'h0;
      tx_mlt_o <= '0;
    end
    else if (bit_en_q)
    begin
      tx_sh_q <= nib_en_q ? tx_grp_d : {tx_sh_q[3:0], 1'b0};
      tx_nrzi_q <= tx_nrzi_d;
      mlt_st_q <= mlt_st_d;
      tx_mlt_o.p <= mlt_st_d == 2'h1;
      tx_mlt_o.n <= mlt_st_d == 2'h3;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rx_s1_q <= '0;
      rx_s2_q <= '0;
      rx_s3_q <= '0;
    end
    else
    begin
      rx_s1_q <= rx_mlt_i;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  // phase restarts on each line transition
  assign rx_trans = rx_s2_q != rx_s3_q;
  assign rx_bit_en = !rx_trans && rx_ph_q == fecdc_pkg::RX_SAMPLE_PH;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rx_ph_q <= 2'h0;
      lock_cnt_q <= 7'h00;
      rx_lock_o <= 1'b0;
    end
    else
    begin
      rx_ph_q <= rx_trans ? 2'h0 : rx_ph_q + 2'h1;
      if (rx_trans)
      begin
        lock_cnt_q <= 7'h00;
        rx_lock_o <= 1'b1;
      end
      else if (rx_bit_en && lock_cnt_q == fecdc_pkg::LOCK_LAST)
        rx_lock_o <= 1'b0;
      else if (rx_bit_en)
        lock_cnt_q <= lock_cnt_q + 7'h01;
    end
  end

  // a change of line level is an NRZI transition
  assign rx_nrzi_d = rx_nrzi_q ^ (rx_s2_q != rx_smp_q);
  assign rx_nrz = rx_nrzi_d ^ rx_nrzi_q;
  assign rx_plain = rx_nrz ^ rx_key;

  fecdc_lfsr u_dsc (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .step_i(rx_bit_en),
    .load_i(!desc_lock_q),
    .feed_i(!rx_nrz),
    .key_o(rx_key)
  );

  // The descrambler assumes idle while loading, so a link must come up
  // on idles; a frame arriving first is lost until it relocks.
  always_ff @(posedge clock_i)
  begin
    if (srst_i || !rx_lock_o)
    begin
      rx_smp_q <= '0;
      rx_nrzi_q <= 1'b0;
      desc_cnt_q <= 4'h0;
      desc_lock_q <= 1'b0;
      rx_win_q <= 10'h000;
      rx_chk_q <= 1'b0;
    end
    else
    begin
      rx_chk_q <= rx_bit_en;
      if (rx_bit_en)
      begin
        rx_smp_q <= rx_s2_q;
        rx_nrzi_q <= rx_nrzi_d;
        // serial bits into a parallel window
        // Ones while loading, so stale key bits cannot mimic a start pair.
        rx_win_q <= {rx_win_q[8:0], desc_lock_q ? rx_plain : 1'b1};
        if (desc_cnt_q == fecdc_pkg::DESC_LAST)
          desc_lock_q <= 1'b1;
        else
          desc_cnt_q <= desc_cnt_q + 4'h1;
      end
    end
  end

  // start pair is J then K
  assign jk_hit = rx_chk_q && !aligned_q && desc_lock_q &&
                  rx_win_q == {fecdc_pkg::CG_J, fecdc_pkg::CG_K};
  assign grp_rdy = rx_chk_q && aligned_q && grp_cnt_q == fecdc_pkg::GRP_LAST;

  always_ff @(posedge clock_i)
  begin
    if (srst_i || !rx_lock_o)
    begin
      aligned_q <= 1'b0;
      grp_cnt_q <= 3'h0;
    end
    else if (jk_hit)
    begin
      aligned_q <= 1'b1;
      grp_cnt_q <= 3'h0;
    end
    else if (rx_chk_q && aligned_q)
    begin
      grp_cnt_q <= grp_rdy ? 3'h0 : grp_cnt_q + 3'h1;
      if (grp_rdy && ending_q)
        aligned_q <= 1'b0;
    end
  end

  // One group of latency lets both preamble nibbles fill the J/K slots.
  always_ff @(posedge clock_i)
  begin
    if (srst_i || !rx_lock_o)
    begin
      rx_stage_q <= '0;
      rx_mii_o <= '0;
      rx_nib_stb_o <= 1'b0;
      saw_t_q <= 1'b0;
      ending_q <= 1'b0;
    end
    else
    begin
      rx_nib_stb_o <= jk_hit || grp_rdy;
      if (jk_hit)
      begin
        rx_mii_o <= '{en: 1'b1, er: 1'b0, d: fecdc_pkg::NIB_PRE};
        rx_stage_q <= '{en: 1'b1, er: 1'b0, d: fecdc_pkg::NIB_PRE};
        saw_t_q <= 1'b0;
        ending_q <= 1'b0;
      end
      else if (grp_rdy)
      begin
        // one nibble per group toward the MAC
        rx_mii_o <= rx_stage_q;
        ending_q <= 1'b0;
        if (!ending_q)
        begin
          unique case (dec_sym)
            fecdc_pkg::SYM_DATA:
              rx_stage_q <= '{en: 1'b1, er: saw_t_q, d: dec_nib};
            fecdc_pkg::SYM_T:
            begin
              rx_stage_q <= '0;
              saw_t_q <= 1'b1;
            end
            fecdc_pkg::SYM_R:
            begin
              rx_stage_q <= '{en: 1'b0, er: !saw_t_q, d: 4'h0};
              ending_q <= 1'b1;
            end
            // idle ends the frame, never data
            fecdc_pkg::SYM_IDLE:
            begin
              rx_stage_q <= '{en: 1'b0, er: 1'b1, d: 4'h0};
              ending_q <= 1'b1;
            end
            // error and invalid groups flag receive error
            default:
              rx_stage_q <= '{en: 1'b1, er: 1'b1, d: 4'h0};
          endcase
        end
        else
          rx_stage_q <= '0;
      end
    end
  end

  sequence s_tx_jk;
    tx_grp_q == fecdc_pkg::CG_J ##20 tx_grp_q == fecdc_pkg::CG_K;
  endsequence

  sequence s_tx_tr;
    tx_grp_q == fecdc_pkg::CG_T ##20 tx_grp_q == fecdc_pkg::CG_R;
  endsequence

  a_tx_jk_pair: assert property (
    nib_en_q && tx_st_q == fecdc_pkg::TX_IDLE && tx_mii_i.en |=> s_tx_jk)
    else $error("start pair J/K not sent");

  a_tx_tr_idle: assert property (
    nib_en_q && tx_st_q == fecdc_pkg::TX_DATA && !tx_mii_i.en |=>
    s_tx_tr ##20 tx_grp_q == fecdc_pkg::CG_IDLE)
    else $error("end pair or idle missing");

  a_enc_zero_f: assert property (
    nib_en_q && tx_st_q == fecdc_pkg::TX_DATA && tx_mii_i.en &&
    !tx_mii_i.er && !bypass_i && tx_mii_i.d inside {4'h0, 4'hf} |=>
    tx_grp_q == ($past(tx_mii_i.d) == 4'h0 ? fecdc_pkg::CG_D0 :
                 fecdc_pkg::CG_DF))
    else $error("data nibble coded wrongly");

  a_tx_bypass: assert property (
    nib_en_q && tx_st_q == fecdc_pkg::TX_DATA && tx_mii_i.en && bypass_i
    |=> tx_grp_q == {$past(tx_sym4_i), $past(tx_mii_i.d)})
    else $error("bypass symbol altered");

  a_mlt_exclusive: assert property (
    !(tx_mlt_o.p && tx_mlt_o.n) and ($rose(tx_mlt_o.p) |-> !$past(tx_mlt_o.n)))
    else $error("line streams overlap");

  a_nrzi_toggle: assert property (
    bit_en_q |=> (tx_mlt_o != $past(tx_mlt_o)) == $past(tx_nrz))
    else $error("line step does not follow coded bit");

  a_rx_strobe_ph: assert property (
    rx_bit_en |=> !rx_bit_en [*3])
    else $error("bit strobes closer than one line bit");

  a_rx_phase_reset: assert property (
    rx_trans |=> rx_ph_q == 2'h0)
    else $error("phase not restarted on transition");

  a_rx_preamble: assert property (
    jk_hit |=> rx_mii_o.en && rx_mii_o.d == fecdc_pkg::NIB_PRE &&
    rx_stage_q.d == fecdc_pkg::NIB_PRE && rx_nib_stb_o)
    else $error("preamble nibbles not substituted");

  a_rx_ctrl_drop: assert property (
    grp_rdy && !ending_q && dec_sym inside {fecdc_pkg::SYM_T,
    fecdc_pkg::SYM_R, fecdc_pkg::SYM_IDLE} |=> !rx_stage_q.en)
    else $error("control group delivered as data");

  a_rx_err_code: assert property (
    grp_rdy && !ending_q && dec_sym inside {fecdc_pkg::SYM_H,
    fecdc_pkg::SYM_BAD} |=> rx_stage_q.en && rx_stage_q.er)
    else $error("bad group without error");
endmodule // fecdc_top

// ===== test/fecdc_lp_model.sv
// Remote link partner model that returns the line signal after a cable delay.
`timescale 1ns/1ps
module fecdc_lp_model #(
  parameter int DLY = 7
) (
  // Clock
  input wire logic clock_i,
  // Line from the device and cable control
  input wire fecdc_pkg::fecdc_mlt_t line_i,
  input wire logic mute_i,
  // Line back to the device
  output fecdc_pkg::fecdc_mlt_t line_o
);
  fecdc_pkg::fecdc_mlt_t dly_q [DLY];

  initial
  begin
    for (int i = 0; i < DLY; i++)
    begin
      dly_q[i] = '0;
    end
  end

  always @(posedge clock_i)
  begin
    dly_q[0] <= line_i;
    for (int i = 1; i < DLY; i++)
    begin
      dly_q[i] <= dly_q[i-1];
    end
  end

  // A pulled cable carries no signal, which reads as the zero level.
  assign line_o = mute_i ? '0 : dly_q[DLY-1];
endmodule // fecdc_lp_model

// ===== test/fecdc_top_tb_top.sv
// Self-checking loopback testbench of the line codec.
`timescale 1ns/1ps
module fecdc_top_tb_top;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  fecdc_pkg::fecdc_mii_t tx_mii = '0;
  logic tx_sym4 = 1'b0;
  logic bypass = 1'b0;
  logic mute = 1'b0;
  logic tx_nib_stb;
  fecdc_pkg::fecdc_mlt_t tx_mlt;
  fecdc_pkg::fecdc_mlt_t rx_mlt;
  fecdc_pkg::fecdc_mii_t rx_mii;
  logic rx_nib_stb;
  logic rx_lock;
  int err_total = 0;
  int n_tests = 0;
  integer seed = 32'h87e2;
  logic [5:0] got_q [$];
  logic [5:0] exp_q [$];
  fecdc_pkg::fecdc_mlt_t lvl_q = '0;
  logic seen_nz = 1'b0;
  logic last_p = 1'b0;
  logic [1:0] lvl_exp;
  logic [4:0] enc_tab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
    5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic [4:0] bad_tab [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06,
    5'h08, 5'h0c, 5'h10, 5'h19};

  always #25 clock_i = ~clock_i;

  fecdc_top u_fecdc_top (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .tx_mii_i(tx_mii),
    .tx_sym4_i(tx_sym4),
    .bypass_i(bypass),
    .tx_nib_stb_o(tx_nib_stb),
    .tx_mlt_o(tx_mlt),
    .rx_mlt_i(rx_mlt),
    .rx_mii_o(rx_mii),
    .rx_nib_stb_o(rx_nib_stb),
    .rx_lock_o(rx_lock)
  );

  fecdc_lp_model u_fecdc_lp_model (
    .clock_i(clock_i),
    .line_i(tx_mlt),
    .mute_i(mute),
    .line_o(rx_mlt)
  );

  task automatic chk(input string what, input logic [5:0] exp,
                     input logic [5:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Received nibbles are taken at the falling edge, where they have settled.
  always @(negedge clock_i)
  begin
    if (rx_nib_stb === 1'b1 && (rx_mii.en | rx_mii.er) === 1'b1)
      got_q.push_back({rx_mii.en, rx_mii.er, rx_mii.d});
  end

  always @(negedge clock_i)
  begin
    if (tx_mlt !== lvl_q)
    begin
      if (lvl_q != 2'b00)
        lvl_exp = 2'b00;
      else if (seen_nz)
        lvl_exp = last_p ? 2'b01 : 2'b10;
      else
        lvl_exp = (tx_mlt == 2'b11) ? 2'b10 : tx_mlt;
      chk("line level", {4'h0, lvl_exp}, {4'h0, tx_mlt});
      if (tx_mlt != 2'b00)
      begin
        seen_nz = 1'b1;
        last_p = tx_mlt.p;
      end
      lvl_q = tx_mlt;
    end
  end

  // One nibble is handed over; it is sampled at the next transmit strobe.
  task automatic put(input logic en, input logic er, input logic byp,
                     input logic [4:0] v);
    int k;
    k = 0;
    @(negedge clock_i);
    while (tx_nib_stb !== 1'b1 && k < 100)
    begin
      @(negedge clock_i);
      k++;
    end
    @(posedge clock_i);
    tx_mii <= '{en: en, er: er, d: v[3:0]};
    tx_sym4 <= v[4];
    bypass <= byp;
  endtask

  function automatic logic [5:0] expect_nib(int mode, int i, logic [3:0] d);
    if (mode == 1 && i == 0)
      return 6'h30;
    if (mode == 2)
      return {2'b10, 4'(i)};
    if (mode == 3)
      return 6'h30;
    if (mode == 4)
      return (i == 0) ? 6'h20 : 6'h10;
    return {2'b10, d};
  endfunction

  // Modes: 0 plain, 1 coding error first, 2 raw data codes, 3 raw invalid,
  // 4 raw idle in mid-frame.
  task automatic frame(input string what, input int mode, input int n);
    logic [3:0] d;
    logic [4:0] v;
    got_q.delete();
    exp_q.delete();
    put(1'b1, 1'b0, 1'b0, 5'h05);
    put(1'b1, 1'b0, 1'b0, 5'h05);
    exp_q.push_back({2'b10, fecdc_pkg::NIB_PRE});
    exp_q.push_back({2'b10, fecdc_pkg::NIB_PRE});
    for (int i = 0; i < n; i++)
    begin
      d = 4'($random(seed));
      v = (mode == 2) ? enc_tab[i] : (mode == 3) ? bad_tab[i] :
          (mode == 4) ? ((i == 1) ? fecdc_pkg::CG_IDLE : fecdc_pkg::CG_D0) :
          {1'b0, d};
      put(1'b1, mode == 1 && i == 0, mode >= 2, v);
      exp_q.push_back(expect_nib(mode, i, d));
    end
    repeat (8) put(1'b0, 1'b0, 1'b0, 5'h00);
    chk({what, " count"}, 6'(exp_q.size()), 6'(got_q.size()));
    for (int i = 0; i < exp_q.size(); i++)
    begin
      chk(what, exp_q[i], (i < got_q.size()) ? got_q[i] : 6'hxx);
    end
    $display("test %s done", what);
  endtask

  task automatic wait_lock(input logic lvl, input int lim);
    int k;
    k = 0;
    while (rx_lock !== lvl && k < lim)
    begin
      @(negedge clock_i);
      k++;
    end
    chk("receive lock", {5'h00, lvl}, {5'h00, rx_lock});
  endtask

  initial
  begin
    repeat (60000) @(posedge clock_i);
    err_total++;
    $display("MISMATCH watchdog expected done seen timeout");
    stop_test();
  end

  initial
  begin
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    wait_lock(1'b1, 2000);
    repeat (300) @(posedge clock_i);
    frame("one nibble", 0, 1);
    for (int f = 0; f < 5; f++)
    begin
      frame("random", 0, 2 + ($unsigned($random(seed)) % 14));
    end
    frame("raw data codes", 2, 16);
    frame("raw invalid codes", 3, 10);
    frame("coding error", 1, 4);
    frame("idle inside frame", 4, 2);
    @(posedge clock_i);
    mute <= 1'b1;
    wait_lock(1'b0, (fecdc_pkg::LOCK_BITS + 16) * fecdc_pkg::OVS);
    @(posedge clock_i);
    mute <= 1'b0;
    wait_lock(1'b1, 2000);
    repeat (300) @(posedge clock_i);
    frame("after relock", 0, 6);
    stop_test();
  end
endmodule // fecdc_top_tb_top
